// ### rtl/ctis_defs.svh
// Constants for the counter/timer and interrupt status block
`ifndef CTIS_DEFS_SVH
`define CTIS_DEFS_SVH
// Bus geometry
`define CTIS_AW          8
`define CTIS_DW          32
`define CTIS_IDX_HI      5
`define CTIS_IDX_LO      2
`define CTIS_TOP_HI      7
`define CTIS_TOP_LO      6
`define CTIS_LANE_HI     1
`define CTIS_LANE_LO     0
`define CTIS_TOP_ZERO    2'h0
`define CTIS_LANE_ZERO   2'h0
`define CTIS_PAD         24'h000000
// Register indexes, byte address is four times the index
`define CTIS_IDX_CRA     4'h2
`define CTIS_IDX_ACR     4'h4
`define CTIS_IDX_ISR     4'h5
`define CTIS_IDX_IMR     4'h5
`define CTIS_IDX_CTU     4'h6
`define CTIS_IDX_CT_PRESET_UPPER    4'h6
`define CTIS_IDX_CTL     4'h7
`define CTIS_IDX_CT_PRESET_LOWER    4'h7
`define CTIS_IDX_OUTPUT_CONFIG_REG    4'hd
`define CTIS_IDX_START   4'he
`define CTIS_IDX_STOP    4'hf
// Field positions
`define CTIS_ACR_HI      6
`define CTIS_ACR_LO      4
`define CTIS_OUTPUT_CONFIG_REG_HI     3
`define CTIS_OUTPUT_CONFIG_REG_LO     2
`define CTIS_CMD_HI      7
`define CTIS_CMD_LO      4
`define CTIS_MODE_TIMER  2
// Commands
`define CTIS_CMD_TO_OFF  8'hc0
`define CTIS_CMD_BRK_RST 4'h5
// General output 3 source select
`define CTIS_OP3_OPR     2'h0
`define CTIS_OP3_CT      2'h1
`define CTIS_OP3_TXB     2'h2
`define CTIS_OP3_RXB     2'h3
// Counter clock sources
`define CTIS_SRC_IP2     3'h0
`define CTIS_SRC_TXCA    3'h1
`define CTIS_SRC_TXCB    3'h2
`define CTIS_SRC_X1D_C   3'h3
`define CTIS_SRC_IP2_T   3'h4
`define CTIS_SRC_IP2D    3'h5
`define CTIS_SRC_X1      3'h6
`define CTIS_SRC_X1D     3'h7
// Synchronised pin vector: ip2, txca, txcb, x1
`define CTIS_NSRC        4
`define CTIS_PIN_IP2     0
`define CTIS_PIN_TXCA    1
`define CTIS_PIN_TXCB    2
`define CTIS_PIN_X1      3
// Counts and reset values
`define CTIS_DIV_LAST    4'hf
`define CTIS_DIV_ZERO    4'h0
`define CTIS_CNT_ONE     16'h0001
`define CTIS_CNT_ZERO    16'h0000
`define CTIS_RST_BYTE    8'h00
`define CTIS_RST_ACR     3'h0
`define CTIS_RST_OUTPUT_CONFIG_REG    2'h0
`define CTIS_RST_SRC     4'h0
`endif

// ### rtl/ctis_pkg.sv
// Types and state records for the counter/timer and interrupt status block
`include "ctis_defs.svh"
package ctis_pkg;
  typedef enum logic {CTIS_IDLE, CTIS_RUN} ctis_run_t;

  typedef struct packed {
    logic                  ack;
    logic [7:0]            prdata;
    logic [7:0]            irq_mask;
    logic [7:0]            ct_preset_upper;
    logic [7:0]            ct_preset_lower;
    logic [2:0]            ct_mode;
    logic [1:0]            op3_sel;
    logic [15:0]           count;
    ctis_run_t             run;
    logic                  wave;
    logic                  tc;
    logic                  half;
    logic                  isr_ctr;
    logic                  isr_brk_a;
    logic                  isr_rx_a;
    logic                  pop_d;
    logic [`CTIS_NSRC-1:0] src_d;
    logic                  irq_n;
    logic                  op3_o;
    logic                  op3_oe;
  } ctis_state_t;

  typedef struct packed {
    logic [`CTIS_NSRC-1:0] s1;
    logic [`CTIS_NSRC-1:0] s2;
  } ctis_sync_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       out;
  } ctis_div_t;
endpackage

// ### rtl/ctis_sync.sv
// Two-stage synchroniser for the counter clock source pins
`timescale 1ns/1ps
`include "ctis_defs.svh"
module ctis_sync
  import ctis_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic [`CTIS_NSRC-1:0] pin_in,
  output logic      [`CTIS_NSRC-1:0] pin_sync
);
  ctis_sync_t st;
  ctis_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st    = st;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st.s1;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '{s1: `CTIS_RST_SRC, s2: `CTIS_RST_SRC};
    end else begin
      st <= nxt_st;
    end
  end

  assign pin_sync = st.s2;
endmodule

// ### rtl/ctis_div16.sv
// Divide-by-sixteen of a tick pulse train
`timescale 1ns/1ps
`include "ctis_defs.svh"
module ctis_div16
  import ctis_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic tick_in,
  output logic      tick_out
);
  ctis_div_t st;
  ctis_div_t nxt_st;

  // One output pulse per sixteen input pulses
  always_comb begin
    nxt_st     = st;
    nxt_st.out = 1'b0;
    if (tick_in) begin
      nxt_st.cnt = st.cnt + 4'h1;
      nxt_st.out = (st.cnt == `CTIS_DIV_LAST);
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '{cnt: `CTIS_DIV_ZERO, out: 1'b0};
    end else begin
      st <= nxt_st;
    end
  end

  assign tick_out = st.out;
endmodule

// ### rtl/ctis_top.sv
// Counter/timer with interrupt status, mask and APB register slave
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "ctis_defs.svh"
module ctis_top
  import ctis_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`CTIS_AW-1:0] paddr,
  input  wire logic [`CTIS_DW-1:0] pwdata,
  output logic      [`CTIS_DW-1:0] prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                tx_ready_a,
  input  wire logic                tx_ready_b,
  input  wire logic                rx_a_int_sel,
  input  wire logic                rx_a_push,
  input  wire logic                rx_a_full,
  input  wire logic                rx_a_nonempty,
  input  wire logic                rx_a_pop,
  input  wire logic                brk_change_a,
  input  wire logic                chan_b_rx_irq,
  input  wire logic                chan_b_brk_irq,
  input  wire logic                ip_change_irq,
  input  wire logic                opr_bit3,
  input  wire logic                chan_b_tx_clk,
  input  wire logic                chan_b_rx_clk,
  input  wire logic                ip2_pin,
  input  wire logic                txca_pin,
  input  wire logic                txcb_pin,
  input  wire logic                x1_pin,
  output logic                     irq_out_n,
  output logic                     general_out_3_o,
  output logic                     general_out_3_oe,
  output logic      [7:0]          interrupt_status_reg,
  output logic                     ct_running
);
  ctis_state_t st;
  ctis_state_t nxt_st;

  logic [`CTIS_NSRC-1:0] pin_sync;
  logic [`CTIS_NSRC-1:0] pin_rise;
  logic                  ip2_div;
  logic                  x1_div;
  logic                  access;
  logic                  done;
  logic                  rd_ok;
  logic                  wr_ok;
  logic                  wr_cra;
  logic                  wr_acr;
  logic                  wr_imr;
  logic                  wr_ct_preset_upper;
  logic                  wr_ct_preset_lower;
  logic                  wr_output_config_reg;
  logic                  rd_start;
  logic                  rd_stop;
  logic                  tick;
  logic                  timer_mode;
  logic                  ct_out;
  logic                  ctr_set;
  logic                  ctr_clr;
  logic                  rx_set;
  logic                  brk_clr;
  logic [7:0]            irq_status;
  logic [15:0]           preset;

  // Word decode of a register index on the APB address
  function automatic logic idx_hit(input logic [`CTIS_AW-1:0] a, input logic [3:0] idx);
    idx_hit = (a[`CTIS_TOP_HI:`CTIS_TOP_LO] == `CTIS_TOP_ZERO) &&
              (a[`CTIS_LANE_HI:`CTIS_LANE_LO] == `CTIS_LANE_ZERO) &&
              (a[`CTIS_IDX_HI:`CTIS_IDX_LO] == idx);
  endfunction

  // Counter clock pick from the mode and source field
  function automatic logic src_tick(input logic [2:0] mode,
                                    input logic [`CTIS_NSRC-1:0] rise,
                                    input logic ip2d,
                                    input logic x1d);
    case (mode)
      `CTIS_SRC_IP2:   src_tick = rise[`CTIS_PIN_IP2];
      `CTIS_SRC_TXCA:  src_tick = rise[`CTIS_PIN_TXCA];
      `CTIS_SRC_TXCB:  src_tick = rise[`CTIS_PIN_TXCB];
      `CTIS_SRC_X1D_C: src_tick = x1d;
      `CTIS_SRC_IP2_T: src_tick = rise[`CTIS_PIN_IP2];
      `CTIS_SRC_IP2D:  src_tick = ip2d;
      `CTIS_SRC_X1:    src_tick = rise[`CTIS_PIN_X1];
      `CTIS_SRC_X1D:   src_tick = x1d;
      default:         src_tick = 1'b0;
    endcase
  endfunction

  // Source pins cross into the system clock before any use
  ctis_sync u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_in   ({x1_pin, txcb_pin, txca_pin, ip2_pin}),
    .pin_sync (pin_sync)
  );

  // Rising edge per synchronised source
  genvar gi;
  generate
    for (gi = 0; gi < `CTIS_NSRC; gi = gi + 1) begin : g_rise
      assign pin_rise[gi] = pin_sync[gi] & ~st.src_d[gi];
    end
  endgenerate

  // Divided sources for the divide-by-sixteen selections
  ctis_div16 u_div_ip2 (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .tick_in  (pin_rise[`CTIS_PIN_IP2]),
    .tick_out (ip2_div)
  );

  ctis_div16 u_div_x1 (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .tick_in  (pin_rise[`CTIS_PIN_X1]),
    .tick_out (x1_div)
  );

  // APB phase tracking: one wait state, effects at the pready edge
  assign access = psel & penable;
  assign done   = access & st.ack;
  assign pready = st.ack;

  // Legal reads and writes per index
  assign rd_ok = idx_hit(paddr, `CTIS_IDX_ISR) | idx_hit(paddr, `CTIS_IDX_CTU) |
                 idx_hit(paddr, `CTIS_IDX_CTL) | idx_hit(paddr, `CTIS_IDX_START) |
                 idx_hit(paddr, `CTIS_IDX_STOP);
  assign wr_ok = idx_hit(paddr, `CTIS_IDX_CRA) | idx_hit(paddr, `CTIS_IDX_ACR) |
                 idx_hit(paddr, `CTIS_IDX_IMR) | idx_hit(paddr, `CTIS_IDX_CT_PRESET_UPPER) |
                 idx_hit(paddr, `CTIS_IDX_CT_PRESET_LOWER) | idx_hit(paddr, `CTIS_IDX_OUTPUT_CONFIG_REG);
  assign pslverr = st.ack & (pwrite ? ~wr_ok : ~rd_ok);

  // Completed accesses that act
  assign wr_cra   = done & pwrite & idx_hit(paddr, `CTIS_IDX_CRA);
  assign wr_acr   = done & pwrite & idx_hit(paddr, `CTIS_IDX_ACR);
  assign wr_imr   = done & pwrite & idx_hit(paddr, `CTIS_IDX_IMR);
  assign wr_ct_preset_upper  = done & pwrite & idx_hit(paddr, `CTIS_IDX_CT_PRESET_UPPER);
  assign wr_ct_preset_lower  = done & pwrite & idx_hit(paddr, `CTIS_IDX_CT_PRESET_LOWER);
  assign wr_output_config_reg  = done & pwrite & idx_hit(paddr, `CTIS_IDX_OUTPUT_CONFIG_REG);
  assign rd_start = done & ~pwrite & idx_hit(paddr, `CTIS_IDX_START);
  assign rd_stop  = done & ~pwrite & idx_hit(paddr, `CTIS_IDX_STOP);

  // Mode and count clock
  assign timer_mode = st.ct_mode[`CTIS_MODE_TIMER];
  assign tick       = src_tick(st.ct_mode, pin_rise, ip2_div, x1_div);
  assign preset     = {st.ct_preset_upper, st.ct_preset_lower};

  // Counter/timer output level before the pin mux
  assign ct_out = timer_mode ? st.wave : ~st.tc;

  // Live status vector, unmasked
  assign irq_status = {ip_change_irq, chan_b_brk_irq, chan_b_rx_irq,
                tx_ready_b, st.isr_ctr, st.isr_brk_a, st.isr_rx_a, tx_ready_a};

  // Event sources for the sticky status bits
  assign ctr_clr = rd_stop | (wr_cra & (pwdata[7:0] == `CTIS_CMD_TO_OFF));
  assign brk_clr = wr_cra & (pwdata[`CTIS_CMD_HI:`CTIS_CMD_LO] == `CTIS_CMD_BRK_RST);
  assign rx_set  = rx_a_int_sel ? (rx_a_push & rx_a_full) :
                   (rx_a_push | (st.pop_d & rx_a_nonempty));

  // Next-state logic
  always_comb begin
    nxt_st       = st;
    ctr_set      = 1'b0;
    nxt_st.src_d = pin_sync;
    nxt_st.pop_d = rx_a_pop;

    // Bus handshake and read data capture
    nxt_st.ack = access & ~st.ack;
    if (access & ~st.ack & ~pwrite) begin
      nxt_st.prdata = `CTIS_RST_BYTE;
      if (idx_hit(paddr, `CTIS_IDX_ISR)) begin
        nxt_st.prdata = irq_status;
      end else if (idx_hit(paddr, `CTIS_IDX_CTU)) begin
        nxt_st.prdata = st.count[15:8];
      end else if (idx_hit(paddr, `CTIS_IDX_CTL)) begin
        nxt_st.prdata = st.count[7:0];
      end
    end

    // Register writes
    if (wr_imr) begin
      nxt_st.irq_mask = pwdata[7:0];
    end
    if (wr_ct_preset_upper) begin
      nxt_st.ct_preset_upper = pwdata[7:0];
    end
    if (wr_ct_preset_lower) begin
      nxt_st.ct_preset_lower = pwdata[7:0];
    end
    if (wr_acr) begin
      nxt_st.ct_mode = pwdata[`CTIS_ACR_HI:`CTIS_ACR_LO];
    end
    if (wr_output_config_reg) begin
      nxt_st.op3_sel = pwdata[`CTIS_OUTPUT_CONFIG_REG_HI:`CTIS_OUTPUT_CONFIG_REG_LO];
    end

    // Counter/timer sequencing
    if (rd_start) begin
      nxt_st.run   = CTIS_RUN;
      nxt_st.count = preset;
      nxt_st.wave  = 1'b1;
      nxt_st.tc    = 1'b0;
      nxt_st.half  = 1'b0;
    end else if ((st.run == CTIS_RUN) && tick) begin
      if (timer_mode && (st.count <= `CTIS_CNT_ONE)) begin
        // Count at one or less: reload for the next half-period
        nxt_st.count = preset;
        nxt_st.wave  = ~st.wave;
        nxt_st.half  = ~st.half;
        ctr_set      = st.half;
      end else begin
        nxt_st.count = st.count - `CTIS_CNT_ONE;
        if (!timer_mode && (st.count == `CTIS_CNT_ONE)) begin
          nxt_st.tc = 1'b1;
          ctr_set   = 1'b1;
        end
      end
    end

    // Stop halts only the counter mode
    if (rd_stop && !timer_mode) begin
      nxt_st.run = CTIS_IDLE;
      nxt_st.tc  = 1'b0;
    end

    // Sticky status bits, set wins over clear
    nxt_st.isr_ctr   = ctr_set | (st.isr_ctr & ~ctr_clr);
    nxt_st.isr_brk_a = brk_change_a | (st.isr_brk_a & ~brk_clr);
    nxt_st.isr_rx_a  = rx_set | (st.isr_rx_a & ~rx_a_pop);

    // Masked interrupt, active low
    nxt_st.irq_n = ~|(irq_status & st.irq_mask);

    // General output 3 source mux, mask has no say here
    case (st.op3_sel)
      `CTIS_OP3_OPR: begin
        nxt_st.op3_o  = ~opr_bit3;
        nxt_st.op3_oe = 1'b1;
      end
      `CTIS_OP3_CT: begin
        nxt_st.op3_o  = 1'b0;
        nxt_st.op3_oe = ~ct_out;
      end
      `CTIS_OP3_TXB: begin
        nxt_st.op3_o  = chan_b_tx_clk;
        nxt_st.op3_oe = 1'b1;
      end
      `CTIS_OP3_RXB: begin
        nxt_st.op3_o  = chan_b_rx_clk;
        nxt_st.op3_oe = 1'b1;
      end
      default: begin
        nxt_st.op3_o  = 1'b1;
        nxt_st.op3_oe = 1'b0;
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '{ack: 1'b0, prdata: `CTIS_RST_BYTE, irq_mask: `CTIS_RST_BYTE,
              ct_preset_upper: `CTIS_RST_BYTE, ct_preset_lower: `CTIS_RST_BYTE,
              ct_mode: `CTIS_RST_ACR, op3_sel: `CTIS_RST_OUTPUT_CONFIG_REG,
              count: `CTIS_CNT_ZERO, run: CTIS_IDLE,
              wave: 1'b1, tc: 1'b0, half: 1'b0,
              isr_ctr: 1'b0, isr_brk_a: 1'b0, isr_rx_a: 1'b0,
              pop_d: 1'b0, src_d: `CTIS_RST_SRC,
              irq_n: 1'b1, op3_o: 1'b1, op3_oe: 1'b0};
    end else begin
      st <= nxt_st;
    end
  end

  // Outputs
  assign prdata               = {`CTIS_PAD, st.prdata};
  assign irq_out_n            = st.irq_n;
  assign general_out_3_o      = st.op3_o;
  assign general_out_3_oe     = st.op3_oe;
  assign interrupt_status_reg = irq_status;
  assign ct_running           = (st.run == CTIS_RUN);
endmodule

// ### tb/ctis_top_properties.sv
// Assertion checker on the counter/timer and interrupt status block ports
`timescale 1ns/1ps
`include "ctis_defs.svh"
module ctis_top_properties (
  input wire logic                clk_sys,
  input wire logic                rstn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [`CTIS_AW-1:0] paddr,
  input wire logic [`CTIS_DW-1:0] pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                tx_ready_a,
  input wire logic                tx_ready_b,
  input wire logic                rx_a_int_sel,
  input wire logic                rx_a_push,
  input wire logic                rx_a_full,
  input wire logic                rx_a_pop,
  input wire logic                brk_change_a,
  input wire logic                irq_out_n,
  input wire logic [7:0]          interrupt_status_reg,
  input wire logic                ct_running
);
  logic [3:0] ix;
  logic       acc;
  // Decoded word index and a completed good transfer
  assign ix  = paddr[`CTIS_IDX_HI:`CTIS_IDX_LO];
  assign acc = psel && penable && pready && !pslverr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_start; acc && !pwrite && ix == 4'he; endsequence
  sequence s_stop; acc && !pwrite && ix == 4'hf; endsequence
  sequence s_brk_cmd; acc && pwrite && ix == 4'h2 && pwdata[7:4] == 4'h5 && !brk_change_a;
  endsequence
  property p_tx_mirror; interrupt_status_reg[0] == tx_ready_a &&
    interrupt_status_reg[4] == tx_ready_b; endproperty
  property p_irq_quiet; interrupt_status_reg == 8'h00 |=> irq_out_n; endproperty
  property p_stop_clr; s_stop |=> !interrupt_status_reg[3]; endproperty
  property p_start_run; s_start |=> ct_running; endproperty
  property p_reset_idle; $rose(rstn) |-> !ct_running && irq_out_n &&
    interrupt_status_reg[3:1] == 3'h0; endproperty
  property p_brk_set; brk_change_a |=> interrupt_status_reg[2]; endproperty
  property p_brk_clr; s_brk_cmd |=> !interrupt_status_reg[2]; endproperty
  property p_push_set; rx_a_push && (!rx_a_int_sel || rx_a_full) |=> interrupt_status_reg[1];
  endproperty
  property p_pop_clr; rx_a_pop && !rx_a_push |=> !interrupt_status_reg[1]; endproperty
  a_tx_mirror: assert property (p_tx_mirror)
    else $error("status mirror differs from transmitter ready");
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt low with empty status");
  a_stop_clr: assert property (p_stop_clr)
    else $error("counter ready not cleared by stop");
  a_start_run: assert property (p_start_run)
    else $error("start did not run the counter");
  a_reset_idle: assert property (p_reset_idle)
    else $error("state not idle after reset");
  a_brk_set: assert property (p_brk_set)
    else $error("break change not flagged");
  a_brk_clr: assert property (p_brk_clr)
    else $error("break change not cleared by command");
  a_push_set: assert property (p_push_set)
    else $error("receive flag not set on load");
  a_pop_clr: assert property (p_pop_clr)
    else $error("receive flag not cleared on read");
endmodule

// ### tb/ctis_src_model.sv
// Counter clock sources on the external input pins
`timescale 1ns/1ps
`include "ctis_defs.svh"
module ctis_src_model (
  input  wire logic clk_sys,
  output logic      ip2_pin,
  output logic      txca_pin,
  output logic      txcb_pin,
  output logic      x1_pin
);
  // Pins stand low between bursts, so no stray edge reaches the counter
  logic [`CTIS_NSRC-1:0] lvl = 4'h0;
  assign ip2_pin  = lvl[`CTIS_PIN_IP2];
  assign txca_pin = lvl[`CTIS_PIN_TXCA];
  assign txcb_pin = lvl[`CTIS_PIN_TXCB];
  assign x1_pin   = lvl[`CTIS_PIN_X1];
  // Pulse one source pin n times, four clocks high and four low
  task automatic pulses(input int n, input int pin);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      lvl[pin] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lvl[pin] <= 1'b0;
    end
  endtask
endmodule

// ### tb/test_counter_timer_irq_status.sv
// Self-checking bench for the counter/timer and interrupt status block
`timescale 1ns/1ps
`include "ctis_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_counter_timer_irq_status;
  logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rd, interrupt_status_reg;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, err, irq_out_n, general_out_3_o, general_out_3_oe, ct_running;
  logic tx_ready_a = 1'b0, tx_ready_b = 1'b0, rx_a_int_sel = 1'b0, rx_a_push = 1'b0;
  logic rx_a_full = 1'b0, rx_a_nonempty = 1'b0, rx_a_pop = 1'b0, brk_change_a = 1'b0;
  logic chan_b_rx_irq = 1'b0, chan_b_brk_irq = 1'b0, ip_change_irq = 1'b0, opr_bit3 = 1'b1;
  logic ip2_pin, txca_pin, txcb_pin, x1_pin;
  logic chan_b_tx_clk = 1'b1, chan_b_rx_clk = 1'b0;
  // Source pin and divide-by-sixteen use of each mode and source code
  int pin_of[8] = '{0, 1, 2, 3, 0, 0, 3, 3};
  int div_of[8] = '{0, 0, 0, 1, 0, 1, 0, 1};
  int fails = 0, compares = 0;
  // Clock at 20 MHz
  always #25 clk_sys = ~clk_sys;
  ctis_src_model src_i (.clk_sys(clk_sys), .ip2_pin(ip2_pin), .txca_pin(txca_pin),
    .txcb_pin(txcb_pin), .x1_pin(x1_pin));
  ctis_top ctis_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_ready_a(tx_ready_a), .tx_ready_b(tx_ready_b), .rx_a_int_sel(rx_a_int_sel),
    .rx_a_push(rx_a_push), .rx_a_full(rx_a_full), .rx_a_nonempty(rx_a_nonempty),
    .rx_a_pop(rx_a_pop), .brk_change_a(brk_change_a), .chan_b_rx_irq(chan_b_rx_irq),
    .chan_b_brk_irq(chan_b_brk_irq), .ip_change_irq(ip_change_irq), .opr_bit3(opr_bit3),
    .chan_b_tx_clk(chan_b_tx_clk), .chan_b_rx_clk(chan_b_rx_clk), .ip2_pin(ip2_pin),
    .txca_pin(txca_pin), .txcb_pin(txcb_pin), .x1_pin(x1_pin), .irq_out_n(irq_out_n),
    .general_out_3_o(general_out_3_o), .general_out_3_oe(general_out_3_oe),
    .interrupt_status_reg(interrupt_status_reg), .ct_running(ct_running));
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic rdc(input logic [3:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    `CHK($sformatf("reg %h", ix), e, rd)
  endtask
  task automatic tick(input int n, input int pin = 0);
    src_i.pulses(n, pin);
    cyc(2);
  endtask
  task automatic push(input logic f);
    rx_a_full <= f;
    rx_a_push <= 1'b1;
    cyc(1);
    rx_a_push <= 1'b0;
  endtask
  task automatic pop;
    rx_a_pop <= 1'b1;
    cyc(1);
    rx_a_pop <= 1'b0;
    cyc(2);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rdc(4'h5, 8'h00);
    tx_ready_a <= 1'b1;
    apb(1'b0, 4'h0, 8'h00);
    `CHK("slverr", 1'b1, err)
    // Counter mode from the external pin, output 3 on the counter
    apb(1'b1, 4'h4, 8'h00);
    apb(1'b1, 4'hd, 8'h04);
    apb(1'b1, 4'h6, 8'h00);
    apb(1'b1, 4'h7, 8'h03);
    apb(1'b1, 4'h5, 8'h08);
    tick(2);
    `CHK("run", 1'b0, ct_running)
    rdc(4'h7, 8'h00);
    `CHK("o3", 1'b0, general_out_3_o)
    apb(1'b0, 4'he, 8'h00);
    tick(2);
    rdc(4'h7, 8'h01);
    `CHK("oe", 1'b0, general_out_3_oe)
    tick(1);
    rdc(4'h5, 8'h09);
    `CHK("oe", 1'b1, general_out_3_oe)
    `CHK("irq", 1'b0, irq_out_n)
    tick(1);
    apb(1'b0, 4'hf, 8'h00);
    rdc(4'h6, 8'hff);
    rdc(4'h7, 8'hff);
    rdc(4'h5, 8'h01);
    `CHK("oe", 1'b0, general_out_3_oe)
    `CHK("irq", 1'b1, irq_out_n)
    apb(1'b0, 4'he, 8'h00);
    rdc(4'h7, 8'h03);
    apb(1'b1, 4'h7, 8'h05);
    tick(1);
    rdc(4'h7, 8'h02);
    apb(1'b0, 4'he, 8'h00);
    rdc(4'h7, 8'h05);
    apb(1'b0, 4'hf, 8'h00);
    // Timer mode, preset two
    apb(1'b1, 4'h4, 8'h40);
    apb(1'b1, 4'h7, 8'h02);
    apb(1'b0, 4'he, 8'h00);
    cyc(2);
    `CHK("oe", 1'b0, general_out_3_oe)
    tick(2);
    `CHK("oe", 1'b1, general_out_3_oe)
    rdc(4'h5, 8'h01);
    tick(2);
    `CHK("oe", 1'b0, general_out_3_oe)
    rdc(4'h5, 8'h09);
    apb(1'b0, 4'hf, 8'h00);
    cyc(2);
    rdc(4'h5, 8'h01);
    `CHK("run", 1'b1, ct_running)
    tick(1);
    apb(1'b1, 4'h7, 8'h03);
    tick(1);
    `CHK("oe", 1'b1, general_out_3_oe)
    tick(2);
    `CHK("oe", 1'b1, general_out_3_oe)
    tick(1);
    `CHK("oe", 1'b0, general_out_3_oe)
    rdc(4'h5, 8'h09);
    apb(1'b1, 4'h2, 8'hc0);
    rdc(4'h5, 8'h01);
    // Every mode and source code: three edges on its pin, sixteen if divided
    apb(1'b1, 4'h7, 8'h05);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 4'h4, 8'(c << 4));
      apb(1'b0, 4'he, 8'h00);
      tick((div_of[c] != 0) ? 16 : 3, pin_of[c]);
      rdc(4'h7, (div_of[c] != 0) ? 8'h04 : 8'h02);
    end
    // Break change and its clear command
    brk_change_a <= 1'b1;
    cyc(1);
    brk_change_a <= 1'b0;
    rdc(4'h5, 8'h05);
    apb(1'b1, 4'h2, 8'h50);
    rdc(4'h5, 8'h01);
    // Receiver ready, then FIFO full
    rx_a_nonempty <= 1'b1;
    push(1'b0);
    rdc(4'h5, 8'h03);
    pop();
    rdc(4'h5, 8'h03);
    rx_a_nonempty <= 1'b0;
    pop();
    rdc(4'h5, 8'h01);
    rx_a_int_sel <= 1'b1;
    push(1'b0);
    rdc(4'h5, 8'h01);
    push(1'b1);
    rdc(4'h5, 8'h03);
    pop();
    rdc(4'h5, 8'h01);
    // Masked sources leave the pin alone but still read back
    {chan_b_rx_irq, chan_b_brk_irq, ip_change_irq} <= 3'b111;
    tx_ready_b <= 1'b1;
    cyc(2);
    `CHK("irq", 1'b1, irq_out_n)
    rdc(4'h5, 8'hf1);
    apb(1'b1, 4'h5, 8'h80);
    cyc(2);
    `CHK("irq", 1'b0, irq_out_n)
    rdc(4'h5, 8'hf1);
    // Output 3 follows the channel B clocks on the two clock selects
    apb(1'b1, 4'hd, 8'h08);
    cyc(2);
    `CHK("o3", 1'b1, general_out_3_o)
    apb(1'b1, 4'hd, 8'h0c);
    cyc(2);
    `CHK("o3", 1'b0, general_out_3_o)
    `CHK("oe", 1'b1, general_out_3_oe)
    // Reset in mid-run clears sticky bits, mask and select, and idles the timer
    opr_bit3 <= 1'b0;
    brk_change_a <= 1'b1;
    cyc(1);
    brk_change_a <= 1'b0;
    `CHK("run", 1'b1, ct_running)
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
    `CHK("run", 1'b0, ct_running)
    `CHK("irq", 1'b1, irq_out_n)
    rdc(4'h5, 8'hf1);
    `CHK("o3", 1'b1, general_out_3_o)
    `CHK("oe", 1'b1, general_out_3_oe)
    wrap_up();
  end
endmodule
bind ctis_top ctis_top_properties ctis_top_properties_i (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .tx_ready_a(tx_ready_a), .tx_ready_b(tx_ready_b), .rx_a_int_sel(rx_a_int_sel),
  .rx_a_push(rx_a_push), .rx_a_full(rx_a_full), .rx_a_pop(rx_a_pop),
  .brk_change_a(brk_change_a), .irq_out_n(irq_out_n),
  .interrupt_status_reg(interrupt_status_reg), .ct_running(ct_running));
